// [hdl/rcra_ctrl.sv]
// Main control register action bits with AXI4-Lite access, soft resets and abort sequencing.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - Bit 31 resets core except registers, timing
// - Bit 30 resets only the timing generator
// - Bit 29 returns register block to reset
// - Action bits self-clear when action completes
// - Writing zero triggers nothing, keeps pending
// - Bit 26 aborts running RF test
// - Tx abort: finish byte, then CRC
// - Rx with address match: stop at packet end
// - Rx without address: stop now, radio off
// - Bit 25 aborts current advertising event
module rcra_ctrl
  import rcra_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sys_soft_rst,
  output logic             tg_soft_rst,
  output logic             reg_soft_rst,
  input  wire logic        rftest_tx_active,
  input  wire logic        rftest_rx_active,
  input  wire logic        access_addr_found,
  input  wire logic        byte_boundary,
  input  wire logic        crc_done,
  input  wire logic        rx_pkt_end,
  output logic             pc_finish_byte,
  output logic             pc_finish_crc,
  output logic             pc_stop_after_pkt,
  output logic             radio_off,
  input  wire logic        adv_event_active,
  input  wire logic        adv_event_done,
  output logic             adv_abort
);

  // Write channel holding registers; address and data may arrive in either order.
  logic        aw_held_r;
  logic        w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  // Read channel output registers.
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // Action request bits held in the control register.
  logic sys_soft_reset_req_r;
  logic timing_gen_soft_reset_req_r;
  logic reg_soft_reset_req_r;
  logic rf_test_abort_req_r;
  logic advertising_abort_req_r;
  logic sys_soft_reset_req_nxt;
  logic timing_gen_soft_reset_req_nxt;
  logic rf_test_abort_req_nxt;
  logic advertising_abort_req_nxt;

  // Abort sequencer state.
  rcra_abort_st_t ab_st_r;
  rcra_abort_st_t ab_st_nxt;

  // Per-channel soft reset pulse counters, channel 0 system and channel 1 timing.
  logic [1:0] rst_req;
  logic [1:0] rst_done;

  // The register block reset clears every control register bit; the bus handshake survives it.
  wire reg_clr = !aresetn || reg_soft_reset_req_r;

  // A write is performed once both halves are held and no response is outstanding.
  wire wr_fire  = aw_held_r && w_held_r && !bvalid_r;
  wire wr_ctrl  = wr_fire && (awaddr_r == CTRL_OFFSET);
  wire wr_known = (awaddr_r == CTRL_OFFSET) || (awaddr_r == STAT_OFFSET);
  wire lane_ok  = wstrb_r[ACTION_LANE];

  // Set terms only look at ones written; zeros leave pending actions alone.
  wire set_sys = wr_ctrl && lane_ok && wdata_r[SYS_RST_BIT];
  wire set_tg  = wr_ctrl && lane_ok && wdata_r[TG_RST_BIT];
  wire set_reg = wr_ctrl && lane_ok && wdata_r[REG_RST_BIT];
  wire set_rft = wr_ctrl && lane_ok && wdata_r[RFT_ABORT_BIT];
  wire set_adv = wr_ctrl && lane_ok && wdata_r[ADV_ABORT_BIT];

  // Completion of the abort actions.
  wire rft_done = (ab_st_r == AB_IDLE) && rf_test_abort_req_r &&
                  !rftest_tx_active && !rftest_rx_active ||
                  (ab_st_r == AB_TX_CRC) && crc_done ||
                  (ab_st_r == AB_RX_PKT) && rx_pkt_end ||
                  (ab_st_r == AB_RF_OFF);
  wire adv_done = advertising_abort_req_r && (adv_event_done || !adv_event_active);

  // Read mux; reserved bits and lower bits read as zero.
  // Reserved bits tied to zero.
  wire [31:0] ctrl_rd = {sys_soft_reset_req_r, timing_gen_soft_reset_req_r,
                         reg_soft_reset_req_r, 2'h0, rf_test_abort_req_r,
                         advertising_abort_req_r, 25'h0};
  wire [31:0] stat_rd = {21'h0, advertising_abort_req_r, timing_gen_soft_reset_req_r,
                         sys_soft_reset_req_r, 2'h0, ab_st_r};
  wire        rd_ctrl = s_axi_araddr == CTRL_OFFSET;
  wire        rd_stat = s_axi_araddr == STAT_OFFSET;
  wire [31:0] rd_data = rd_ctrl ? ctrl_rd : (rd_stat ? stat_rd : 32'h0);
  wire [1:0]  rd_resp = (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_DECERR;

  // Handshake outputs.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write address capture; released once the response is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (bvalid_r && s_axi_bready))
      aw_held_r <= 1'b0;
    else if (s_axi_awvalid && !aw_held_r)
      aw_held_r <= 1'b1;
  end

  // Write data capture.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (bvalid_r && s_axi_bready))
      w_held_r <= 1'b0;
    else if (s_axi_wvalid && !w_held_r)
      w_held_r <= 1'b1;
  end

  // Payload registers need no reset, they are only read while held.
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && !aw_held_r)
      awaddr_r <= s_axi_awaddr;
    if (s_axi_wvalid && !w_held_r)
    begin
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  // Write response, one cycle after both halves are held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_known ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Read answer, registered on the same edge that takes the address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= CTRL_RESET;
      rresp_r  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_resp;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[28:27] == 2'h0)
    else $error("reserved bits read nonzero");

  // Set wins over completion; a zero written changes nothing.
  assign sys_soft_reset_req_nxt        = (sys_soft_reset_req_r && !rst_done[0]) || set_sys;
  assign timing_gen_soft_reset_req_nxt = (timing_gen_soft_reset_req_r && !rst_done[1]) || set_tg;
  assign rf_test_abort_req_nxt         = (rf_test_abort_req_r && !rft_done) || set_rft;
  assign advertising_abort_req_nxt     = (advertising_abort_req_r && !adv_done) || set_adv;
  a_adv_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    adv_abort && !adv_event_active && !set_adv |=> !adv_abort)
    else $error("advertising abort did not clear");
  a_zero_write_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl && !wdata_r[ADV_ABORT_BIT] && adv_abort && adv_event_active && !adv_event_done &&
    !reg_soft_rst |=> adv_abort)
    else $error("zero write disturbed pending abort");

  // Register block reset clears every request, its own bit included.
  always_ff @(posedge aclk)
  begin
    if (reg_clr)
    begin
      sys_soft_reset_req_r        <= CTRL_RESET[SYS_RST_BIT];
      timing_gen_soft_reset_req_r <= CTRL_RESET[TG_RST_BIT];
      reg_soft_reset_req_r        <= CTRL_RESET[REG_RST_BIT];
      rf_test_abort_req_r         <= CTRL_RESET[RFT_ABORT_BIT];
      advertising_abort_req_r     <= CTRL_RESET[ADV_ABORT_BIT];
    end
    else
    begin
      sys_soft_reset_req_r        <= sys_soft_reset_req_nxt;
      timing_gen_soft_reset_req_r <= timing_gen_soft_reset_req_nxt;
      reg_soft_reset_req_r        <= set_reg;
      rf_test_abort_req_r         <= rf_test_abort_req_nxt;
      advertising_abort_req_r     <= advertising_abort_req_nxt;
    end
  end

  a_reg_rst_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_soft_rst |=> !sys_soft_rst && !tg_soft_rst && !reg_soft_rst && !adv_abort)
    else $error("register reset left a request set");

  assign rst_req = {timing_gen_soft_reset_req_r, sys_soft_reset_req_r};

  // One pulse counter each for the system and timing soft resets; the bit stands for exactly the pulse length.
  for (genvar i = 0; i < 2; i++)
  begin : g_rst
    logic [2:0] cnt_r;
    assign rst_done[i] = rst_req[i] && (cnt_r == SOFT_RST_LAST);
    always_ff @(posedge aclk)
    begin
      if (reg_clr || !rst_req[i] || rst_done[i])
        cnt_r <= CNT_RESET;
      else
        cnt_r <= cnt_r + 3'h1;
    end
  end

  // System reset pulse, which spares registers and timing.
  assign sys_soft_rst = sys_soft_reset_req_r;
  assign tg_soft_rst  = timing_gen_soft_reset_req_r;
  // One-cycle pulse to the other registers of the core.
  assign reg_soft_rst = reg_soft_reset_req_r;
  a_sys_rst_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sys_soft_rst) && !reg_soft_rst |-> sys_soft_rst [*2])
    else $error("system soft reset pulse too short");
  a_tg_rst_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tg_soft_rst) && !reg_soft_rst |-> tg_soft_rst [*2])
    else $error("timing soft reset pulse too short");

  // Abort sequencer transitions.
  always_comb
  begin
    ab_st_nxt = ab_st_r;
    case (ab_st_r)
      AB_IDLE:
      begin
        // Choose the stop style from the running test type.
        if (rf_test_abort_req_r && rftest_tx_active)
          ab_st_nxt = AB_TX_BYTE;
        else if (rf_test_abort_req_r && rftest_rx_active && access_addr_found)
          ab_st_nxt = AB_RX_PKT;
        else if (rf_test_abort_req_r && rftest_rx_active)
          ab_st_nxt = AB_RF_OFF;
      end
      // Finish the byte, then process the CRC.
      AB_TX_BYTE:
        if (byte_boundary)
          ab_st_nxt = AB_TX_CRC;
      AB_TX_CRC:
        if (crc_done)
          ab_st_nxt = AB_IDLE;
      // Wait for the packet in flight to end.
      AB_RX_PKT:
        if (rx_pkt_end)
          ab_st_nxt = AB_IDLE;
      // Immediate stop, radio off for one cycle.
      AB_RF_OFF:
        ab_st_nxt = AB_IDLE;
      default:
        ab_st_nxt = AB_IDLE;
    endcase
  end

  // The sequencer belongs to the packet controller, so a register reset does not cut it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ab_st_r <= AB_IDLE;
    else
      ab_st_r <= ab_st_nxt;
  end

  a_rft_tx_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ab_st_r == AB_IDLE && rf_test_abort_req_r && rftest_tx_active |=> pc_finish_byte)
    else $error("tx test abort not started");
  a_tx_byte_crc: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_finish_byte && byte_boundary |=> pc_finish_crc && !radio_off)
    else $error("crc step skipped after byte");
  a_rx_pkt_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_stop_after_pkt && !rx_pkt_end |=> pc_stop_after_pkt)
    else $error("rx abort left before packet end");
  a_rx_rf_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ab_st_r == AB_IDLE && rf_test_abort_req_r && !rftest_tx_active && rftest_rx_active &&
    !access_addr_found |=> radio_off ##1 !radio_off)
    else $error("radio not switched off at once");

  // Packet controller commands come straight from the state flops.
  assign pc_finish_byte    = ab_st_r == AB_TX_BYTE;
  assign pc_finish_crc     = ab_st_r == AB_TX_CRC;
  assign pc_stop_after_pkt = ab_st_r == AB_RX_PKT;
  assign radio_off         = ab_st_r == AB_RF_OFF;

  // Advertising abort stands until the event ends.
  assign adv_abort = advertising_abort_req_r;

endmodule : rcra_ctrl

// [include/rcra_pkg.sv]
// Constants, register layout and state codes for the radio core reset and abort control.
package rcra_pkg;

  // Core clock period.
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Byte addresses of the two registers.
  localparam logic [31:0] CTRL_OFFSET = 32'h0400_0000;
  localparam logic [31:0] STAT_OFFSET = 32'h0400_0004;

  // Action bit positions in the main control register.
  localparam int unsigned SYS_RST_BIT   = 31;
  localparam int unsigned TG_RST_BIT    = 30;
  localparam int unsigned REG_RST_BIT   = 29;
  localparam int unsigned RFT_ABORT_BIT = 26;
  localparam int unsigned ADV_ABORT_BIT = 25;

  // Write strobe lane that carries all action bits.
  localparam int unsigned ACTION_LANE = 3;

  // Field positions in the status register.
  localparam int unsigned STAT_ABORT_LSB = 0;
  localparam int unsigned STAT_SYS_BIT   = 8;
  localparam int unsigned STAT_TG_BIT    = 9;
  localparam int unsigned STAT_ADV_BIT   = 10;

  // Reset value of the main control register.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Length of the system and timing soft reset pulses, rounded up to whole cycles.
  localparam int unsigned SOFT_RST_NS = 80;
  localparam int unsigned SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  SOFT_RST_LAST = 3'(SOFT_RST_CYCLES - 1);
  localparam logic [2:0]  CNT_RESET = 3'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // RF test abort sequencer states, one-hot.
  typedef enum logic [5:0] {
    AB_IDLE    = 6'h01,
    AB_TX_BYTE = 6'h02,
    AB_TX_CRC  = 6'h04,
    AB_RX_PKT  = 6'h08,
    AB_RF_OFF  = 6'h10,
    AB_SPARE   = 6'h20
  } rcra_abort_st_t;

endpackage : rcra_pkg

// [testbench/test_rcra_ctrl.sv]
// Self-checking bench for the radio core reset and abort control block.
`timescale 1ns/1ps
module test_rcra_ctrl
  import rcra_pkg::*;
;
  // Bench signals for the ports of the block; the two prot inputs are tied to zero.
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr  = 32'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] araddr  = 32'h0;
  logic [31:0] rdata;
  logic [3:0]  wstrb   = 4'h0;
  logic [3:0]  strb    = 4'hf;  // Strobes offered by the next write.
  logic [3:0]  pls     = 4'h0;  // Byte boundary, crc done, packet end, advert done.
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tx_act = 1'b0, rx_act = 1'b0, aa_found = 1'b0, adv_act = 1'b0;
  logic        sys_rst, tg_rst, reg_rst, fin_byte, fin_crc, stop_pkt, rf_off, adv_abort;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          pcnt [4]    = '{default: 0};  // High cycles of the three resets and radio off.

  rcra_ctrl i_rcra_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sys_soft_rst(sys_rst), .tg_soft_rst(tg_rst),
    .reg_soft_rst(reg_rst), .rftest_tx_active(tx_act), .rftest_rx_active(rx_act),
    .access_addr_found(aa_found), .byte_boundary(pls[0]), .crc_done(pls[1]),
    .rx_pkt_end(pls[2]), .pc_finish_byte(fin_byte), .pc_finish_crc(fin_crc),
    .pc_stop_after_pkt(stop_pkt), .radio_off(rf_off), .adv_event_active(adv_act),
    .adv_event_done(pls[3]), .adv_abort(adv_abort)
  );

  // Free-running core clock.
  initial
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;

  // Pulse lengths are counted at the sampling edge, independent of bench timing.
  always @(posedge aclk)
  begin
    pcnt[0] = pcnt[0] + int'(sys_rst === 1'b1);
    pcnt[1] = pcnt[1] + int'(tg_rst === 1'b1);
    pcnt[2] = pcnt[2] + int'(reg_rst === 1'b1);
    pcnt[3] = pcnt[3] + int'(rf_off === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Every task that waits on the clock ends 1 ns after an edge, so checks never race the edge updates.
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : wt

  task automatic pulse(input int i);
    @(posedge aclk) pls[i] <= 1'b1;
    @(posedge aclk) pls[i] <= 1'b0;
    #1;
  endtask : pulse

  // Each channel holds until its own handshake edge; only the watchdog ends a wait.
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid)
      begin
        bready <= 1'b0;
        chk(32'(bresp), 32'(er), "write response");
        chk(32'({awvalid, wvalid}), 32'h0, "response before both halves");
        done = 1'b1;
      end
    end
    #1;
  endtask : axw

  // The answer must follow the taken address.
  task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid)
      begin
        rready <= 1'b0;
        chk(rdata, ed, "read data");
        chk(32'(rresp), 32'(er), "read response");
        chk(32'(arvalid), 32'h0, "answer before address taken");
        done = 1'b1;
      end
    end
    #1;
  endtask : axr

  // Reset values, unmapped places and the read-only status word.
  task automatic t_bus();
    pcnt = '{default: 0};
    axr(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
    axr(STAT_OFFSET, 32'(AB_IDLE), RESP_OKAY);
    axr(32'h0400_0008, 32'h0, RESP_DECERR);
    axw(32'h0400_0010, 32'h8000_0000, RESP_DECERR);
    axw(STAT_OFFSET, 32'hffff_ffff, RESP_OKAY);
    axr(STAT_OFFSET, 32'(AB_IDLE), RESP_OKAY);
    chk(pcnt[0], 0, "reset from unmapped write");
    $display("bus test done");
  endtask : t_bus

  // Each soft reset alone, then reserved bits and a zero write.
  task automatic t_soft();
    int bit_no [3] = '{SYS_RST_BIT, TG_RST_BIT, REG_RST_BIT};
    int len [3]    = '{SOFT_RST_CYCLES, SOFT_RST_CYCLES, 1};
    for (int i = 0; i < 3; i++)
    begin
      pcnt = '{default: 0};
      axw(CTRL_OFFSET, 32'h1 << bit_no[i], RESP_OKAY);
      wt(6);
      for (int j = 0; j < 3; j++) chk(pcnt[j], (i == j) ? len[i] : 0, "reset cycles");
      axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    end
    pcnt = '{default: 0};
    axw(CTRL_OFFSET, 32'h1800_0000, RESP_OKAY);
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    axw(CTRL_OFFSET, 32'h0, RESP_OKAY);
    wt(4);
    chk(pcnt[0] + pcnt[1] + pcnt[2], 0, "action on zero write");
    strb = 4'h7;
    axw(CTRL_OFFSET, 32'h8000_0000, RESP_OKAY);
    strb = 4'hf;
    wt(4);
    chk(pcnt[0], 0, "action without top byte lane");
    $display("soft reset test done");
  endtask : t_soft

  // Advertising_abort_req stays pending over a zero write; a register reset drops it.
  task automatic t_adv();
    @(posedge aclk) adv_act <= 1'b1;
    axw(CTRL_OFFSET, 32'h0200_0000, RESP_OKAY);
    chk(adv_abort, 1'b1, "advertising_abort_req raised");
    axw(CTRL_OFFSET, 32'h0, RESP_OKAY);
    wt(3);
    chk(adv_abort, 1'b1, "advertising_abort_req kept");
    axr(CTRL_OFFSET, 32'h0200_0000, RESP_OKAY);
    pulse(3);
    wt(2);
    chk(adv_abort, 1'b0, "advertising_abort_req done");
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    axw(CTRL_OFFSET, 32'h0200_0000, RESP_OKAY);
    axw(CTRL_OFFSET, 32'h2000_0000, RESP_OKAY);
    wt(3);
    chk(adv_abort, 1'b0, "cleared by register reset");
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    @(posedge aclk) adv_act <= 1'b0;
    axw(CTRL_OFFSET, 32'h0200_0000, RESP_OKAY);
    chk(adv_abort, 1'b0, "idle advertising_abort_req done");
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    $display("advert test done");
  endtask : t_adv

  // RF test abort in transmit, receive with address and receive without.
  task automatic t_rf();
    @(posedge aclk) tx_act <= 1'b1;
    axw(CTRL_OFFSET, 32'h0400_0000, RESP_OKAY);
    wt(4);
    chk({fin_byte, fin_crc}, 2'b10, "finish byte");
    axr(STAT_OFFSET, 32'(AB_TX_BYTE), RESP_OKAY);
    pulse(0);
    chk({fin_byte, fin_crc}, 2'b01, "finish crc");
    axr(CTRL_OFFSET, 32'h0400_0000, RESP_OKAY);
    pulse(1);
    wt(2);
    chk({fin_byte, fin_crc}, 2'b00, "tx stopped");
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    axr(STAT_OFFSET, 32'(AB_IDLE), RESP_OKAY);
    @(posedge aclk) tx_act <= 1'b0;
    @(posedge aclk) {rx_act, aa_found} <= 2'b11;
    pcnt = '{default: 0};
    axw(CTRL_OFFSET, 32'h0400_0000, RESP_OKAY);
    wt(4);
    chk(stop_pkt, 1'b1, "stop after packet");
    pulse(2);
    wt(2);
    chk(stop_pkt, 1'b0, "rx stopped");
    chk(pcnt[3], 0, "radio kept on");
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    @(posedge aclk) aa_found <= 1'b0;
    axw(CTRL_OFFSET, 32'h0400_0000, RESP_OKAY);
    wt(3);
    chk(pcnt[3], 1, "radio off once");
    chk(stop_pkt, 1'b0, "no packet wait");
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    @(posedge aclk) rx_act <= 1'b0;
    axw(CTRL_OFFSET, 32'h0400_0000, RESP_OKAY);
    axr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    chk({fin_byte, fin_crc, stop_pkt, rf_off}, 4'h0, "idle abort no action");
    $display("rf abort test done");
  endtask : t_rf

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    bad_count++;
    complete_run();
  end

  // Main sequence after 20 cycles of reset.
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2);
    t_bus();
    t_soft();
    t_adv();
    t_rf();
    complete_run();
  end
endmodule : test_rcra_ctrl
